// ---- hw/xpl_link_shift.sv ----
// first-rank shift register on the falling shift clock
`timescale 1ns/100ps
`default_nettype none
`include "xpl_regs.svh"
module xpl_link_shift #(
  parameter int P_OUTS = `XPL_OUTS
) (
  input wire logic i_link_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire xpl_pkg::xpl_pins_t i_pins,
  input wire logic i_serial_data_input,
  input wire logic i_req_tgl,
  input wire xpl_pkg::xpl_cmd_t i_cmd,
  output logic o_ack_tgl,
  output xpl_pkg::xpl_image_t o_hold,
  output logic o_serial_data_output
);
  import xpl_pkg::*;

  typedef struct packed {
    logic en_s1;
    logic en_s2;
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic ack;
    xpl_image_t shreg;
    xpl_image_t hold;
    logic sout;
  } xpl_link_state_t;

  if (P_OUTS != `XPL_OUTS) begin : g_chk
    $error("xpl_link_shift: output count fixed by package types");
  end

  xpl_link_state_t q;
  xpl_link_state_t d;
  xpl_op_t op;
  logic req_new;
  logic [`XPL_IMG_W-1:0] sh_vec;
  logic sh_top;
  xpl_entry_t cmd_data;
  logic [`XPL_ADDR_W-1:0] cmd_addr;

  assign sh_vec = q.shreg;
  assign sh_top = sh_vec[`XPL_IMG_W-1];
  assign cmd_data = i_cmd.data;
  assign cmd_addr = i_cmd.addr;
  // control pins are launched with the shift clock, so no synchroniser
  assign op = xpl_decode(i_pins);
  assign req_new = q.req_s2 != q.req_seen;

  always_comb begin
    d = q;
    d.en_s1 = i_clk_en;
    d.en_s2 = q.en_s1;
    if (q.en_s2) begin
      d.req_s1 = i_req_tgl;
      d.req_s2 = q.req_s1;
      if (op == XPL_OP_SHIFT) begin
        // extra output flop makes the delay a full image length
        d.sout = sh_top;
        d.shreg = {sh_vec[`XPL_IMG_W-2:0], i_serial_data_input};
      end
      if (req_new) begin
        d.req_seen = q.req_s2;
        d.ack = ~q.ack;
        unique case (i_cmd.kind)
          XPL_CMD_ALL: begin
            for (int i = 0; i < `XPL_OUTS; i++) begin
              d.shreg[i] = cmd_data;
            end
          end
          XPL_CMD_ONE: begin
            if (cmd_addr <= `XPL_LAST_ADDR) begin
              d.shreg[cmd_addr] = cmd_data;
            end
          end
          XPL_CMD_SNAP: begin
          end
        endcase
        // every request refreshes the stable copy read by the system side
        d.hold = d.shreg;
      end
    end
  end

  // falling edge samples the serial input
  always_ff @(negedge i_link_clk or posedge i_reset) begin
    if (i_reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_ack_tgl = q.ack;
  assign o_hold = q.hold;
  assign o_serial_data_output = q.sout;

  sequence s_shift_step;
    q.en_s2 && (op == XPL_OP_SHIFT) && !req_new;
  endsequence

  property p_shift_in;
    @(negedge i_link_clk) disable iff (i_reset)
    s_shift_step |=> sh_vec[0] == $past(i_serial_data_input);
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("serial input not shifted in");

  property p_sout;
    @(negedge i_link_clk) disable iff (i_reset)
    s_shift_step |=> q.sout == $past(sh_top);
  endproperty
  a_sout: assert property (p_sout)
    else $error("serial output not fed from image top");

  property p_bcast;
    @(negedge i_link_clk) disable iff (i_reset)
    (q.en_s2 && req_new && i_cmd.kind == XPL_CMD_ALL)
      |=> q.shreg == {`XPL_OUTS{$past(cmd_data)}};
  endproperty
  a_bcast: assert property (p_bcast)
    else $error("broadcast did not fill every entry");

  property p_parallel;
    @(negedge i_link_clk) disable iff (i_reset)
    (q.en_s2 && req_new && i_cmd.kind == XPL_CMD_ONE
      && cmd_addr <= `XPL_LAST_ADDR)
      |=> q.shreg[$past(cmd_addr)] == $past(cmd_data);
  endproperty
  a_parallel: assert property (p_parallel)
    else $error("parallel write missed its entry");

  property p_quiet;
    @(negedge i_link_clk) disable iff (i_reset)
    (q.en_s2 && !req_new && op != XPL_OP_SHIFT) |=> $stable(q.shreg);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("first rank changed without an operation");
endmodule
`default_nettype wire

// ---- hw/xpl_pkg.sv ----
// types shared by the crosspoint programming latches
`default_nettype none
package xpl_pkg;
  `include "xpl_regs.svh"

  typedef struct packed {
    logic enable;
    logic [`XPL_CHAN_W-1:0] channel;
  } xpl_entry_t;

  typedef xpl_entry_t [`XPL_OUTS-1:0] xpl_image_t;
  typedef logic [`XPL_OUTS-1:0][`XPL_INS-1:0] xpl_select_t;

  typedef struct packed {
    logic write_strobe_n;
    logic update_n;
    logic shift_clk_level;
    logic load_mode_select;
    logic chip_select_n;
    logic [`XPL_ADDR_W-1:0] entry_address;
    xpl_entry_t entry_data;
  } xpl_pins_t;

  typedef enum logic [2:0] {
    XPL_OP_NONE, XPL_OP_ALL, XPL_OP_ONE, XPL_OP_SHIFT, XPL_OP_UPDATE
  } xpl_op_t;

  typedef enum logic [1:0] {XPL_CMD_SNAP, XPL_CMD_ALL, XPL_CMD_ONE} xpl_kind_t;

  typedef struct packed {
    xpl_kind_t kind;
    logic [`XPL_ADDR_W-1:0] addr;
    xpl_entry_t data;
  } xpl_cmd_t;

  typedef enum logic {XPL_ST_IDLE, XPL_ST_WAIT} xpl_state_t;

  typedef struct packed {
    xpl_image_t image;
    xpl_select_t select;
  } xpl_rank2_t;

  // pin combination to operation; cases are disjoint
  function automatic xpl_op_t xpl_decode(input xpl_pins_t p);
    xpl_op_t op;
    op = XPL_OP_NONE;
    if (!p.chip_select_n) begin
      if (!p.write_strobe_n) begin
        if (p.update_n && p.shift_clk_level) begin
          op = p.load_mode_select ? XPL_OP_ONE : XPL_OP_ALL;
        end
      end else if (!p.update_n) begin
        op = XPL_OP_UPDATE;
      end else if (!p.load_mode_select) begin
        op = XPL_OP_SHIFT;
      end
    end
    return op;
  endfunction
endpackage
`default_nettype wire

// ---- hw/xpl_program_latches.sv ----
// crosspoint programming latches: pin decode, second rank, switch decode
`timescale 1ns/100ps
`default_nettype none
`include "xpl_regs.svh"
module xpl_program_latches #(
  parameter int P_OUTS = `XPL_OUTS,
  parameter int P_INS = `XPL_INS
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_link_clk,
  input wire xpl_pkg::xpl_pins_t i_pins,
  input wire logic i_serial_data_input,
  input wire logic i_clear_n,
  output logic o_serial_data_output,
  output xpl_pkg::xpl_image_t o_image,
  output xpl_pkg::xpl_select_t o_select
);
  import xpl_pkg::*;

  typedef struct packed {
    xpl_pins_t pin_s1;
    xpl_pins_t pin_s2;
    xpl_pins_t pin_s3;
    xpl_state_t st;
    logic req_tgl;
    xpl_cmd_t cmd;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
  } xpl_sys_state_t;

  if (P_OUTS != `XPL_OUTS || P_INS != `XPL_INS) begin : g_chk
    $error("xpl_program_latches: sizes fixed by package types");
  end

  // one-hot input select of one entry, none when disabled
  function automatic logic [`XPL_INS-1:0] xpl_onehot(input xpl_entry_t e);
    logic [`XPL_INS-1:0] v;
    v = '0;
    if (e.enable) begin
      v[e.channel] = 1'h1;
    end
    return v;
  endfunction

  xpl_sys_state_t q;
  xpl_sys_state_t d;
  xpl_rank2_t r_q;
  xpl_rank2_t r_d;
  xpl_op_t op;
  logic ack_tgl;
  logic ack_new;
  logic rank2_load;
  logic rank2_clr;
  xpl_image_t link_hold;
  xpl_select_t sel_next;
  xpl_select_t sel_chk;

  xpl_link_shift #(
    .P_OUTS(P_OUTS)
  ) i_xpl_link_shift (
    .i_link_clk(i_link_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_pins(i_pins),
    .i_serial_data_input(i_serial_data_input),
    .i_req_tgl(q.req_tgl),
    .i_cmd(q.cmd),
    .o_ack_tgl(ack_tgl),
    .o_hold(link_hold),
    .o_serial_data_output(o_serial_data_output)
  );

  // enable bit gates the channel number of each entry
  for (genvar g = 0; g < `XPL_OUTS; g++) begin : g_dec
    assign sel_next[g] = xpl_onehot(link_hold[g]);
    assign sel_chk[g] = xpl_onehot(r_q.image[g]);
    // written apart from the decode function, so a slip there shows up
    property p_row;
      @(posedge i_clk_sys) disable iff (rank2_clr)
      r_q.image[g].enable
        ? ($onehot(r_q.select[g]) && r_q.select[g][r_q.image[g].channel])
        : (r_q.select[g] == '0);
    endproperty
    a_row: assert property (p_row)
      else $error("output row not one-hot or not empty");
  end

  // chip select is folded into the decode
  // pins cross as a word: act only once two samples agree, so a capture
  // torn across a pin change is never decoded
  assign op = (q.pin_s2 == q.pin_s3) ? xpl_decode(q.pin_s3) : XPL_OP_NONE;
  assign ack_new = q.ack_s2 != q.ack_seen;
  assign rank2_load = i_clk_en && q.st == XPL_ST_WAIT && ack_new
    && q.cmd.kind == XPL_CMD_SNAP;
  // the clear pin acts without the clock
  assign rank2_clr = i_reset | ~i_clear_n;

  always_comb begin
    d = q;
    if (i_clk_en) begin
      d.pin_s1 = i_pins;
      d.pin_s2 = q.pin_s1;
      d.pin_s3 = q.pin_s2;
      d.ack_s1 = ack_tgl;
      d.ack_s2 = q.ack_s1;
      unique case (q.st)
        XPL_ST_IDLE: begin
          d.ack_seen = q.ack_s2;
          if (op == XPL_OP_ALL || op == XPL_OP_ONE) begin
            d.cmd.kind = (op == XPL_OP_ALL) ? XPL_CMD_ALL : XPL_CMD_ONE;
            d.cmd.addr = q.pin_s3.entry_address;
            d.cmd.data = q.pin_s3.entry_data;
            d.req_tgl = ~q.req_tgl;
            d.st = XPL_ST_WAIT;
          end else if (op == XPL_OP_UPDATE) begin
            // repeated snapshots keep the second rank transparent
            d.cmd.kind = XPL_CMD_SNAP;
            d.req_tgl = ~q.req_tgl;
            d.st = XPL_ST_WAIT;
          end
          // shift or no match: nothing requested
        end
        XPL_ST_WAIT: begin
          if (ack_new) begin
            d.ack_seen = q.ack_s2;
            d.st = XPL_ST_IDLE;
          end
        end
      endcase
    end
  end

  always_comb begin
    r_d = r_q;
    if (rank2_load) begin
      // whole image and decode move on one edge
      r_d.image = link_hold;
      r_d.select = sel_next;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // separate process: only the second rank obeys the clear pin
  always_ff @(posedge i_clk_sys or posedge rank2_clr) begin
    if (rank2_clr) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign o_image = r_q.image;
  assign o_select = r_q.select;

  sequence s_cs_off;
    q.st == XPL_ST_IDLE && q.pin_s3.chip_select_n;
  endsequence

  sequence s_write_req;
    i_clk_en && q.st == XPL_ST_IDLE
      && (op == XPL_OP_ALL || op == XPL_OP_ONE || op == XPL_OP_UPDATE);
  endsequence

  property p_clear;
    @(posedge i_clk_sys) disable iff (i_reset)
    !i_clear_n |-> r_q.image == '0 && r_q.select == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("second rank not cleared");

  property p_update;
    @(posedge i_clk_sys) disable iff (rank2_clr)
    rank2_load |=> r_q.image == $past(link_hold);
  endproperty
  a_update: assert property (p_update)
    else $error("second rank missed the first-rank image");

  property p_together;
    @(posedge i_clk_sys) disable iff (rank2_clr)
    $changed(r_q.image) |-> $past(rank2_load) && r_q.select == sel_chk;
  endproperty
  a_together: assert property (p_together)
    else $error("outputs did not change together");

  property p_select;
    @(posedge i_clk_sys) disable iff (rank2_clr)
    r_q.select == sel_chk;
  endproperty
  a_select: assert property (p_select)
    else $error("switch decode disagrees with second rank");

  property p_gate;
    @(posedge i_clk_sys) disable iff (i_reset)
    s_cs_off |=> q.st == XPL_ST_IDLE && $stable(q.req_tgl);
  endproperty
  a_gate: assert property (p_gate)
    else $error("request made while chip select high");

  property p_request;
    @(posedge i_clk_sys) disable iff (i_reset)
    s_write_req |=> q.st == XPL_ST_WAIT && q.req_tgl != $past(q.req_tgl);
  endproperty
  a_request: assert property (p_request)
    else $error("operation not forwarded to first rank");

  property p_idle;
    @(posedge i_clk_sys) disable iff (i_reset)
    (q.st == XPL_ST_IDLE && (op == XPL_OP_NONE || op == XPL_OP_SHIFT))
      |=> $stable(q.req_tgl);
  endproperty
  a_idle: assert property (p_idle)
    else $error("request without a matching operation");

  property p_freeze;
    @(posedge i_clk_sys) disable iff (rank2_clr)
    !i_clk_en |=> $stable(q) && $stable(r_q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while the clock enable was low");
endmodule
`default_nettype wire

// ---- hw/xpl_regs.svh ----
// constants of the crosspoint programming latches
`ifndef XPL_REGS_SVH
`define XPL_REGS_SVH
// Notes on behaviour
// - clear pin low empties second rank at once; first rank keeps its image.
// - broadcast copies entry data into every entry of the first rank.
// - serial mode shifts serial input into first rank; switch untouched.
// - serial output shows the bit shifted in 45 shift clocks before.
// - parallel mode writes entry data into the addressed entry only.
// - update low with strobe high copies the first rank to the switch.
// - all outputs take their new routing in the same cycle.
// - chip select high blocks shifting and second-rank updates.
// - each output selects exactly one of sixteen inputs, or none.
// - entry is enable bit on top plus four-bit channel number.
// - serial input is sampled on each falling shift clock edge.
// - second rank follows the first rank while update is held low.
`define XPL_OUTS 9
`define XPL_INS 16
`define XPL_CHAN_W 4
`define XPL_ADDR_W 4
`define XPL_IMG_W 45
`define XPL_LAST_ADDR 4'h8
`endif

// ---- verification/xpl_ctrl_model.sv ----
// controller model: drives the programming pins, shift clock and serial line
`timescale 1ns/100ps
`default_nettype none
module xpl_ctrl_model (
  output logic o_link_clk,
  output xpl_pkg::xpl_pins_t o_pins,
  output logic o_serial_data_input,
  input wire logic i_serial_data_output
);
  import xpl_pkg::*;
  logic free_clk = 1'b0;
  logic run = 1'b0;
  logic [44:0] seen;
  initial #1.3 forever #3 free_clk = ~free_clk;
  // shift clock stands still between frames
  assign o_link_clk = free_clk & run;
  initial begin
    o_pins = '1;
    o_serial_data_input = 1'b0;
  end
  // pins launched on the rising edge, so the falling edge sees them settled
  task automatic frame(input xpl_pins_t p, input logic [44:0] d);
    @(posedge free_clk);
    run = 1'b1;
    o_pins = p;
    o_serial_data_input = d[44];
    for (int j = 0; j < 45; j++) begin
      @(posedge free_clk);
      seen[44-j] = i_serial_data_output;
      if (j < 44) o_serial_data_input = d[43-j];
    end
    o_pins.chip_select_n = 1'b1;
    // released line must not keep the last bit
    o_serial_data_input = ~o_serial_data_input;
    // a few idle edges so a command in flight can finish
    repeat (8) @(posedge free_clk);
    // stop while the clock is low, so gating it off makes no extra edge
    @(negedge free_clk);
    run = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verification/xpl_program_latches_bench.sv ----
// self-checking bench for the crosspoint programming latches
`timescale 1ns/100ps
`default_nettype none
module xpl_program_latches_bench;
  import xpl_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b0;
  logic clear_n = 1'b1;
  logic clk_en = 1'b1;
  logic link_clk;
  logic sdi;
  logic sdo;
  xpl_pins_t pins;
  xpl_image_t image;
  xpl_select_t select;
  xpl_image_t img1, img2, exp_img;
  xpl_entry_t val;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #5 clk_sys = ~clk_sys;

  xpl_program_latches i_xpl_program_latches (
    .i_clk_sys(clk_sys),
    .i_reset(reset),
    .i_clk_en(clk_en),
    .i_link_clk(link_clk),
    .i_pins(pins),
    .i_serial_data_input(sdi),
    .i_clear_n(clear_n),
    .o_serial_data_output(sdo),
    .o_image(image),
    .o_select(select)
  );

  xpl_ctrl_model i_xpl_ctrl_model (
    .o_link_clk(link_clk),
    .o_pins(pins),
    .o_serial_data_input(sdi),
    .i_serial_data_output(sdo)
  );

  function automatic xpl_select_t exp_sel(input xpl_image_t im);
    xpl_select_t s;
    s = '0;
    for (int k = 0; k < 9; k++) begin
      if (im[k].enable) s[k][im[k].channel] = 1'b1;
    end
    return s;
  endfunction

  task automatic stop_test;
    if (n_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [143:0] e,
                     input logic [143:0] s);
    n_tests++;
    if (e !== s) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk_out(input xpl_image_t e);
    cmp("o_image", {99'h0, e}, {99'h0, image});
    cmp("o_select", exp_sel(e), select);
  endtask

  task automatic settle(input xpl_image_t e);
    for (int i = 0; i < 60 && image !== e; i++) @(negedge clk_sys);
    chk_out(e);
  endtask

  // ctl order: write strobe_n, update_n, clock level, mode, chip select_n
  task automatic send(input logic [4:0] ctl, input logic [3:0] a,
                      input xpl_entry_t d, input xpl_image_t im);
    i_xpl_ctrl_model.frame({ctl, a, d}, im);
    repeat (4) @(negedge clk_sys);
  endtask

  // hang guard, well above the roughly 600 cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    for (int k = 0; k < 9; k++) begin
      img1[k] = {(k != 4), 4'(15 - k)};
      img2[k] = {(k != 7), 4'(2 * k)};
    end
    // raised after time zero so the stopped link side sees an edge on it
    #1 reset = 1'b1;
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    send(5'h19, 4'h0, 5'h00, '0);
    chk_out('0);
    send(5'h18, 4'h0, 5'h00, img1);
    chk_out('0);
    send(5'h10, 4'h0, 5'h00, '0);
    settle(img1);
    send(5'h18, 4'h0, 5'h00, img2);
    cmp("chain", {99'h0, i_xpl_ctrl_model.seen}, {99'h0, img1});
    chk_out(img1);
    send(5'h11, 4'h0, 5'h00, '0);
    chk_out(img1);
    send(5'h19, 4'h0, 5'h00, img1);
    send(5'h1A, 4'h0, 5'h00, img1);
    send(5'h10, 4'h0, 5'h00, '0);
    settle(img2);
    @(negedge clk_sys);
    clear_n = 1'b0;
    #1 chk_out('0);
    @(negedge clk_sys);
    clear_n = 1'b1;
    send(5'h10, 4'h0, 5'h00, '0);
    settle(img2);
    val = 5'h1A;
    send(5'h0E, 4'h3, val, '0);
    send(5'h0E, 4'h9, 5'h13, '0);
    // clock enable low: an update frame must leave the switch alone
    clk_en = 1'b0;
    send(5'h10, 4'h0, 5'h00, '0);
    chk_out(img2);
    clk_en = 1'b1;
    send(5'h10, 4'h0, 5'h00, '0);
    exp_img = img2;
    exp_img[3] = val;
    settle(exp_img);
    send(5'h0C, 4'h0, 5'h15, '0);
    send(5'h10, 4'h0, 5'h00, '0);
    exp_img = {9{5'h15}};
    settle(exp_img);
    stop_test();
  end
endmodule
`default_nettype wire
